// File: rtl/psm_pkg.sv
// shared types and constants of the partitioned state machine
package psm_pkg;

  // state bits per half: binary uses the low two, one-hot all three
  localparam int unsigned PSM_HALF_W = 3;
  localparam int unsigned PSM_LOG_W = 2;
  localparam int unsigned PSM_NBITS = 2 * PSM_HALF_W;
  localparam int unsigned PSM_A_LSB = 0;
  localparam int unsigned PSM_B_LSB = PSM_HALF_W;
  localparam logic [PSM_HALF_W-1:0] PSM_HALF_RST = 3'h0;
  localparam logic [PSM_NBITS-1:0] PSM_BITS_RST = 6'h00;

  // original state numbers shown on the state id output
  localparam logic [2:0] PSM_ID_S1 = 3'h1;
  localparam logic [2:0] PSM_ID_S2 = 3'h2;
  localparam logic [2:0] PSM_ID_S3 = 3'h3;
  localparam logic [2:0] PSM_ID_S4 = 3'h4;
  localparam logic [2:0] PSM_ID_S5 = 3'h5;
  localparam logic [2:0] PSM_ID_S6 = 3'h6;
  localparam logic [2:0] PSM_ID_NONE = 3'h0;

  typedef enum logic [1:0] {
    PSM_FF_D = 2'h0,
    PSM_FF_T = 2'h1,
    PSM_FF_JK = 2'h2,
    PSM_FF_SR = 2'h3
  } psm_ff_e;

  // first half: the all-zero code is its start state
  typedef enum logic [1:0] {
    PSM_A_S1 = 2'h0,
    PSM_A_S2 = 2'h1,
    PSM_A_S3 = 2'h2,
    PSM_A_IDLE = 2'h3
  } psm_a_e;

  // second half: the all-zero code is its idle state
  typedef enum logic [1:0] {
    PSM_B_IDLE = 2'h0,
    PSM_B_S4 = 2'h1,
    PSM_B_S5 = 2'h2,
    PSM_B_S6 = 2'h3
  } psm_b_e;

  // transition conditions from the surrounding control logic
  typedef struct packed {
    logic go_12;
    logic go_23;
    logic go_31;
    logic go_45;
    logic go_56;
    logic go_64;
    logic x_34;
    logic x_25;
    logic x_61;
    logic x_53;
    logic x_41a;
    logic x_41b;
  } psm_cond_s;

  typedef psm_ff_e [PSM_NBITS-1:0] psm_fftype_t;

endpackage

// File: rtl/psm_sbit.sv
// one state bit with selectable flip-flop type
`timescale 1ns/10ps
module psm_sbit (
  input logic MCLK,
  input logic SYS_RST,
  input logic CLR,
  input psm_pkg::psm_ff_e FF_TYPE,
  input logic WANT,
  output logic Q
);
  import psm_pkg::*;

  logic q_reg;
  logic q_next;
  logic exc_d;
  logic exc_t;
  logic exc_j;
  logic exc_k;

  // excitation from present and wanted value; don't-cares taken as 0
  always_comb begin
    exc_d = WANT;
    exc_t = q_reg ^ WANT;
    exc_j = ~q_reg & WANT;
    exc_k = q_reg & ~WANT;
  end

  always_comb begin
    q_next = q_reg;
    if (CLR) begin
      q_next = 1'b0;
    end else begin
      unique case (FF_TYPE)
        PSM_FF_D: q_next = exc_d; // R9
        PSM_FF_T: q_next = q_reg ^ exc_t; // R9
        PSM_FF_JK: begin
          if (exc_j && exc_k) begin
            q_next = ~q_reg;
          end else if (exc_j) begin
            q_next = 1'b1;
          end else if (exc_k) begin
            q_next = 1'b0;
          end
        end
        PSM_FF_SR: begin
          // set and reset never both high, so no forbidden input
          if (exc_j) begin
            q_next = 1'b1;
          end else if (exc_k) begin
            q_next = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      q_reg <= 1'b0; // R12
    end else begin
      q_reg <= q_next; // R16
    end
  end

  assign Q = q_reg;

endmodule

// File: rtl/psm_top.sv
// six-state control machine split into two linked halves
// Behaviour
// R1 - only one half is ever away from its idle state, the other waits idle.
// R2 - a crossing sends the active half idle and wakes the other in one clock.
// R3 - entering an idle state uses the crossing condition of the full machine.
// R4 - leaving idle needs the crossing condition and the other half's source.
// R5 - an idle state holds unless one of its exit conditions is true.
// R6 - two crossings with the same ends are merged by OR of their conditions.
// R7 - in Moore mode outputs come from state only, with the same sequence.
// R8 - every state bit can work as a D, T, JK or SR flip-flop.
// R9 - each bit is excited as its flip-flop type needs for the wanted change.
// R10 - binary coding uses two bits per half for its four states.
// R11 - one-hot coding keeps one bit per state beside the all-zero start.
// R12 - reset clears every state bit to zero.
// R13 - the all-zero code is the legal start: first half S1, second idle.
// R14 - no unused code can hold the machine; any such code resets it.
// R15 - an illegal code raises a flag and the flag clears all state bits.
// R16 - all bits share one clock edge, so a handoff finishes in one cycle.
`timescale 1ns/10ps
module psm_top (
  input logic MCLK,
  input logic SYS_RST,
  input psm_pkg::psm_cond_s COND,
  input psm_pkg::psm_fftype_t FF_TYPE,
  input logic ONEHOT_SEL,
  input logic MOORE_SEL,
  output logic [psm_pkg::PSM_NBITS-1:0] STATE_BITS,
  output logic [2:0] STATE_ID,
  output logic HALF_B_ACTIVE,
  output logic HANDOFF,
  output logic ILLEGAL
);
  import psm_pkg::*;

  // physical code of a logical half state
  function automatic logic [PSM_HALF_W-1:0] enc(
    input logic [PSM_LOG_W-1:0] s,
    input logic onehot
  );
    logic [PSM_HALF_W-1:0] r;
    r = PSM_HALF_RST;
    if (!onehot) begin
      r = {1'b0, s}; // R10
    end else begin
      unique case (s)
        2'h0: r = 3'h0;
        2'h1: r = 3'h1;
        2'h2: r = 3'h2;
        2'h3: r = 3'h4;
      endcase
    end
    return r;
  endfunction

  // {legal, logical state} of a physical half code
  function automatic logic [PSM_LOG_W:0] dec(
    input logic [PSM_HALF_W-1:0] b,
    input logic onehot
  );
    logic [PSM_LOG_W:0] r;
    r = 3'h0;
    if (!onehot) begin
      r = {~b[2], b[1:0]}; // R10
    end else begin
      unique case (b) // R11
        3'h0: r = 3'h4;
        3'h1: r = 3'h5;
        3'h2: r = 3'h6;
        3'h4: r = 3'h7;
        default: r = 3'h0;
      endcase
    end
    return r;
  endfunction

  logic [PSM_NBITS-1:0] q;
  logic [PSM_NBITS-1:0] want;
  logic [PSM_LOG_W:0] dec_a;
  logic [PSM_LOG_W:0] dec_b;
  psm_a_e a_cur;
  psm_b_e b_cur;
  psm_a_e a_nxt;
  psm_b_e b_nxt;
  logic x_41;
  logic illegal_now;
  logic crossing;
  logic xing_reg;
  logic xing_next;
  logic [2:0] id_reg;
  logic [2:0] id_next;
  logic half_b_reg;
  logic half_b_next;
  logic handoff_reg;
  logic handoff_next;
  logic illegal_reg;
  logic illegal_next;

  always_comb begin
    dec_a = dec(q[PSM_A_LSB +: PSM_HALF_W], ONEHOT_SEL);
    dec_b = dec(q[PSM_B_LSB +: PSM_HALF_W], ONEHOT_SEL);
    a_cur = psm_a_e'(dec_a[PSM_LOG_W-1:0]);
    b_cur = psm_b_e'(dec_b[PSM_LOG_W-1:0]);
  end

  // a bad code in either half, or both halves idle or both busy, is illegal
  always_comb begin
    illegal_now = ~dec_a[PSM_LOG_W] | ~dec_b[PSM_LOG_W]; // R14
    if ((a_cur == PSM_A_IDLE) == (b_cur == PSM_B_IDLE)) begin
      illegal_now = 1'b1; // R1
    end
  end

  assign x_41 = COND.x_41a | COND.x_41b; // R6

  // first half: crossings are tested before internal moves, in both halves
  always_comb begin
    a_nxt = a_cur;
    unique case (a_cur)
      PSM_A_S1: begin
        if (COND.go_12) begin
          a_nxt = PSM_A_S2;
        end
      end
      PSM_A_S2: begin
        if (COND.x_25) begin
          a_nxt = PSM_A_IDLE; // R3
        end else if (COND.go_23) begin
          a_nxt = PSM_A_S3;
        end
      end
      PSM_A_S3: begin
        if (COND.x_34) begin
          a_nxt = PSM_A_IDLE; // R3
        end else if (COND.go_31) begin
          a_nxt = PSM_A_S1;
        end
      end
      PSM_A_IDLE: begin
        if (COND.x_61 && b_cur == PSM_B_S6) begin
          a_nxt = PSM_A_S1; // R4
        end else if (x_41 && b_cur == PSM_B_S4) begin
          a_nxt = PSM_A_S1; // R4
        end else if (COND.x_53 && b_cur == PSM_B_S5) begin
          a_nxt = PSM_A_S3; // R4
        end else begin
          a_nxt = PSM_A_IDLE; // R5
        end
      end
    endcase
  end

  // second half mirrors the first across the dividing line
  always_comb begin
    b_nxt = b_cur;
    unique case (b_cur)
      PSM_B_IDLE: begin
        if (COND.x_34 && a_cur == PSM_A_S3) begin
          b_nxt = PSM_B_S4; // R4
        end else if (COND.x_25 && a_cur == PSM_A_S2) begin
          b_nxt = PSM_B_S5; // R4
        end else begin
          b_nxt = PSM_B_IDLE; // R5
        end
      end
      PSM_B_S4: begin
        if (x_41) begin
          b_nxt = PSM_B_IDLE; // R3
        end else if (COND.go_45) begin
          b_nxt = PSM_B_S5;
        end
      end
      PSM_B_S5: begin
        if (COND.x_53) begin
          b_nxt = PSM_B_IDLE; // R3
        end else if (COND.go_56) begin
          b_nxt = PSM_B_S6;
        end
      end
      PSM_B_S6: begin
        if (COND.x_61) begin
          b_nxt = PSM_B_IDLE; // R3
        end else if (COND.go_64) begin
          b_nxt = PSM_B_S4;
        end
      end
    endcase
  end

  // wanted code of every bit; the bit cells pick their own excitation
  always_comb begin
    want = PSM_BITS_RST;
    want[PSM_A_LSB +: PSM_HALF_W] = enc(a_nxt, ONEHOT_SEL); // R2
    want[PSM_B_LSB +: PSM_HALF_W] = enc(b_nxt, ONEHOT_SEL); // R2
  end

  // changing coding on the fly while the second half is active reads as illegal and restarts from zero
  genvar gi;
  generate
    for (gi = 0; gi < PSM_NBITS; gi++) begin : g_bit
      psm_sbit u_bit (
        .MCLK(MCLK),
        .SYS_RST(SYS_RST),
        .CLR(illegal_now), // R15
        .FF_TYPE(FF_TYPE[gi]), // R8
        .WANT(want[gi]),
        .Q(q[gi])
      );
    end
  endgenerate

  // handoff happens when the active half leaves for idle
  always_comb begin
    crossing = ~illegal_now &
      ((a_cur != PSM_A_IDLE && a_nxt == PSM_A_IDLE) ||
       (b_cur != PSM_B_IDLE && b_nxt == PSM_B_IDLE));
  end

  // moore mode keeps the arrival path as an extra state bit
  always_comb begin
    xing_next = xing_reg;
    if (illegal_now) begin
      xing_next = 1'b0;
    end else if (MOORE_SEL) begin
      xing_next = crossing; // R7
    end else begin
      xing_next = 1'b0;
    end
  end

  always_comb begin
    id_next = PSM_ID_NONE;
    half_b_next = 1'b0;
    if (!illegal_now) begin
      half_b_next = (b_nxt != PSM_B_IDLE);
      if (b_nxt != PSM_B_IDLE) begin
        unique case (b_nxt)
          PSM_B_S4: id_next = PSM_ID_S4;
          PSM_B_S5: id_next = PSM_ID_S5;
          default: id_next = PSM_ID_S6;
        endcase
      end else begin
        unique case (a_nxt)
          PSM_A_S1: id_next = PSM_ID_S1;
          PSM_A_S2: id_next = PSM_ID_S2;
          default: id_next = PSM_ID_S3;
        endcase
      end
    end else begin
      id_next = PSM_ID_S1; // R13
    end
  end

  // mealy output is registered from the inputs; moore from the next value of the state bit
  // so both modes show the same sequence on the same cycle
  always_comb begin
    handoff_next = MOORE_SEL ? xing_next : crossing; // R7
    illegal_next = illegal_now; // R15
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      xing_reg <= 1'b0;
      id_reg <= PSM_ID_S1; // R13
      half_b_reg <= 1'b0;
      handoff_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      xing_reg <= xing_next;
      id_reg <= id_next;
      half_b_reg <= half_b_next;
      handoff_reg <= handoff_next;
      illegal_reg <= illegal_next;
    end
  end

  assign STATE_BITS = q;
  assign STATE_ID = id_reg;
  assign HALF_B_ACTIVE = half_b_reg;
  assign HANDOFF = handoff_reg;
  assign ILLEGAL = illegal_reg;

endmodule

// File: verification/psm_top_assertions.sv
// port assertions of the partitioned state machine
`timescale 1ns/10ps
module psm_top_chk (
  input logic MCLK,
  input logic SYS_RST,
  input psm_pkg::psm_cond_s COND,
  input logic ONEHOT_SEL,
  input logic [psm_pkg::PSM_NBITS-1:0] STATE_BITS,
  input logic [2:0] STATE_ID,
  input logic HALF_B_ACTIVE,
  input logic HANDOFF,
  input logic ILLEGAL
);
  import psm_pkg::*;
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // a live coding change may make the code illegal, so moves need it stable
  a_half_flag: assert property (HALF_B_ACTIVE == (STATE_ID > 3'h3))
    else $error("half flag disagrees with state id");
  // a reset drops the half flag with no crossing, so skip the edge after it
  a_handoff_edge: assert property (!ILLEGAL && !$past(SYS_RST) |->
    HANDOFF == $changed(HALF_B_ACTIVE)) else $error("handoff pulse wrong");
  a_cross_three: assert property (STATE_ID == 3'h3 && COND.x_34 &&
    $stable(ONEHOT_SEL) |=> STATE_ID == 3'h4 && HANDOFF)
    else $error("crossing into second half missed");
  a_idle_hold: assert property (STATE_ID == 3'h5 && !COND.x_53 &&
    $stable(ONEHOT_SEL) |=> HALF_B_ACTIVE) else $error("idle half woke");
  a_merged_exit: assert property (STATE_ID == 3'h4 &&
    (COND.x_41a || COND.x_41b) && $stable(ONEHOT_SEL) |=>
    STATE_ID == 3'h1 && HANDOFF ##1 !HANDOFF)
    else $error("merged crossing wrong");
  a_illegal_clear: assert property (ILLEGAL |->
    STATE_BITS == 6'h00 && STATE_ID == 3'h1 && !HANDOFF)
    else $error("illegal code not cleared");
  a_code_switch: assert property ($changed(ONEHOT_SEL) &&
    HALF_B_ACTIVE |=> ILLEGAL ##1 !ILLEGAL) else $error("no illegal trap");
  a_reset_start: assert property ($fell(SYS_RST) |->
    STATE_BITS == 6'h00 && STATE_ID == 3'h1) else $error("bad start");
endmodule
bind psm_top psm_top_chk i_chk (.MCLK(MCLK), .SYS_RST(SYS_RST), .COND(COND),
  .ONEHOT_SEL(ONEHOT_SEL), .STATE_BITS(STATE_BITS), .STATE_ID(STATE_ID),
  .HALF_B_ACTIVE(HALF_B_ACTIVE), .HANDOFF(HANDOFF), .ILLEGAL(ILLEGAL));

// File: verification/psm_ctrl_model.sv
// surrounding control logic that drives the transition conditions
`timescale 1ns/10ps
module psm_ctrl_model (
  input logic clk,
  input logic rnd_en,
  input logic [3:0] dens,
  input psm_pkg::psm_cond_s fixed_cond,
  output psm_pkg::psm_cond_s cond
);
  import psm_pkg::*;
  logic [11:0] cond_reg = 12'h000;
  logic [11:0] pick;
  assign cond = psm_cond_s'(cond_reg);
  // levels move just after an edge; dens sets busy or quiet traffic
  always @(posedge clk) begin
    for (int i = 0; i < 12; i++) begin
      pick[i] = $urandom_range(7) < dens;
    end
    cond_reg <= rnd_en ? pick : 12'(fixed_cond);
  end
endmodule

// File: verification/testbench.sv
// self-checking bench of the partitioned state machine
`timescale 1ns/10ps
module testbench;
  import psm_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic onehot_sel = 1'b0;
  logic moore_sel = 1'b0;
  logic rnd_en = 1'b0;
  logic chk_on = 1'b0;
  logic [3:0] dens = 4'h0;
  psm_cond_s fixed_cond = '0;
  psm_fftype_t ff_type = '0;
  psm_cond_s cond;
  logic [5:0] state_bits, e_bits;
  logic [2:0] state_id;
  logic half_b_active, handoff, illegal, e_ho, e_il;
  int e_id, la, lb, s, cyc, error_cnt, checks, seed;
  // walk ends in the second half, but the coding switch lands while the machine is still in S2, so it stays legal
  logic [11:0] walk [14] = '{12'h800, 12'h410, 12'h084, 12'h220, 12'h101,
    12'h800, 12'h400, 12'h020, 12'h100, 12'h02a, 12'h080, 12'h048,
    12'h800, 12'h410};
  initial forever #20 mclk = ~mclk;
  psm_top i_dut (.MCLK(mclk), .SYS_RST(sys_rst), .COND(cond),
    .FF_TYPE(ff_type), .ONEHOT_SEL(onehot_sel), .MOORE_SEL(moore_sel),
    .STATE_BITS(state_bits), .STATE_ID(state_id),
    .HALF_B_ACTIVE(half_b_active), .HANDOFF(handoff), .ILLEGAL(illegal));
  psm_ctrl_model i_ctrl (.clk(mclk), .rnd_en(rnd_en), .dens(dens),
    .fixed_cond(fixed_cond), .cond(cond));
  function automatic logic [2:0] enc(int l, logic oh);
    if (!oh) return 3'(l);
    return (l == 0) ? 3'h0 : 3'(1 << (l - 1));
  endfunction
  // -1 marks a code that no state owns
  function automatic int dec(logic [2:0] c, logic oh);
    if (!oh) return c[2] ? -1 : int'(c[1:0]);
    case (c)
      3'h0, 3'h1, 3'h2: return int'(c);
      3'h4: return 3;
      default: return -1;
    endcase
  endfunction
  // a crossing beats the internal move out of the same state
  function automatic int nxt(int st, psm_cond_s c);
    case (st)
      1: return c.go_12 ? 2 : 1;
      2: return c.x_25 ? 5 : (c.go_23 ? 3 : 2);
      3: return c.x_34 ? 4 : (c.go_31 ? 1 : 3);
      4: return (c.x_41a | c.x_41b) ? 1 : (c.go_45 ? 5 : 4);
      5: return c.x_53 ? 3 : (c.go_56 ? 6 : 5);
      default: return c.x_61 ? 1 : (c.go_64 ? 4 : 6);
    endcase
  endfunction
  always @(posedge mclk) begin
    la = dec(e_bits[2:0], onehot_sel);
    lb = dec(e_bits[5:3], onehot_sel);
    e_il = !sys_rst && (la < 0 || lb < 0 || (la == 3) == (lb == 0));
    e_ho = 1'b0;
    e_id = 1;
    if (!sys_rst && !e_il) begin
      s = (la != 3) ? la + 1 : lb + 3;
      e_id = nxt(s, cond);
      e_ho = (s > 3) != (e_id > 3);
    end
    e_bits = {enc(e_id > 3 ? e_id - 3 : 0, onehot_sel),
      enc(e_id < 4 ? e_id - 1 : 3, onehot_sel)};
  end
  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(negedge mclk) begin
    if (chk_on) begin
      check(state_bits, e_bits);
      check({half_b_active, handoff, illegal, state_id},
        {e_id > 3, e_ho, e_il, 3'(e_id)});
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    seed = $urandom(71);
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    chk_on <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      moore_sel <= k[0];
      foreach (walk[i]) begin
        @(posedge mclk);
        fixed_cond <= psm_cond_s'(walk[i]);
      end
      @(posedge mclk);
      fixed_cond <= '0;
      onehot_sel <= ~onehot_sel;
      repeat (3) @(posedge mclk);
    end
    rnd_en <= 1'b1;
    for (int p = 0; p < 8; p++) begin
      for (int b = 0; b < 6; b++) begin
        ff_type[b] <= psm_ff_e'(2'($urandom_range(3)));
      end
      onehot_sel <= 1'($urandom_range(1));
      moore_sel <= 1'($urandom_range(1));
      dens <= p[0] ? 4'h1 : 4'h4;
      repeat (400) @(posedge mclk);
      if (p == 5) begin
        sys_rst <= 1'b1;
        @(posedge mclk);
        sys_rst <= 1'b0;
      end
    end
    give_verdict();
  end
endmodule
